// >>> hdl/cbr_pkg.sv
package cbr_pkg;

  // Clock and timing
  localparam int CLK_MHZ = 50;
  localparam int CLK_HZ = 50_000_000;
  // Rates of the controlled domains; this model runs on sys_clk alone
  localparam int CPU_CLK_KHZ = 500_000;
  localparam int DRAM_CLK_KHZ = 312_500;
  localparam int SUBSYS_CLK_KHZ = 250_000;
  localparam int STRAP_DELAY_NS = 80;
  localparam logic [2:0] STRAP_DELAY_CYC =
    3'((STRAP_DELAY_NS * CLK_MHZ + 999) / 1000);
  localparam int RST_PULSE_NS = 160;
  localparam logic [3:0] RST_PULSE_CYC =
    4'((RST_PULSE_NS * CLK_MHZ + 999) / 1000);
  localparam int WDT_TIMEOUT_S = 2;
  localparam int WDT_CYCLES = WDT_TIMEOUT_S * CLK_HZ;
  localparam int WDT_CNT_W = 27;
  // Arbitrary key value
  localparam logic [7:0] WATCHDOG_LOCK_DEF = 8'hA5;

  // Register indices on the device port, except REG_HOST, which the host answers itself
  localparam logic [2:0] REG_GEN = 3'h0;
  localparam logic [2:0] REG_CORE = 3'h1;
  localparam logic [2:0] REG_CHIP = 3'h2;
  localparam logic [2:0] REG_WDT = 3'h3;
  localparam logic [2:0] REG_SCRATCH = 3'h4;
  localparam logic [2:0] REG_ALT = 3'h5;
  localparam logic [2:0] REG_HOST = 3'h7;

  // General control fields
  localparam int GEN_OWNER = 0;
  localparam int GEN_BOOT = 1;
  localparam int GEN_CPU_DISABLE = 2;
  localparam int GEN_BE = 3;
  localparam int GEN_MGMT = 4;
  // Core reset control fields
  localparam int CORE_FORCE = 0;
  localparam int CORE_CPU_ONLY = 1;
  localparam int CORE_PROTECT = 2;
  // Chip soft reset fields
  localparam int CHIP_ALL = 0;
  localparam int CHIP_SWITCH = 1;
  // Watchdog fields
  localparam int WDT_ENA = 0;
  localparam int WDT_CAUSE = 1;
  localparam int WATCHDOG_LOCK_LO = 8;
  // Host control fields
  localparam int HOST_DMA_ENA = 0;

  // Strap codes
  localparam logic [3:0] STRAP_SI_LE = 4'h0;
  localparam logic [3:0] STRAP_PCIE = 4'h9;
  localparam logic [3:0] STRAP_MGMT0 = 4'hA;
  localparam logic [3:0] STRAP_MGMT31 = 4'hB;
  localparam logic [3:0] STRAP_SI_BE = 4'hC;

  typedef enum logic {CBR_STRAP, CBR_RUN} cbr_dev_st_t;
  typedef enum logic [1:0] {CBR_IDLE, CBR_FWD, CBR_READBACK} cbr_host_st_t;

  // Returns the general control reset image {mgmt, be, dis, boot, owner}
  function automatic logic [4:0] cbr_strap_decode(input logic [3:0] v);
    logic [4:0] r;
    r = 5'h06;
    if (v == STRAP_SI_LE) begin
      r = 5'h03;
    end else if (v == STRAP_SI_BE) begin
      r = 5'h0B;
    end else if (v == STRAP_MGMT0 || v == STRAP_MGMT31) begin
      r = 5'h16;
    end else if (v == STRAP_PCIE) begin
      r = 5'h06;
    end
    return r;
  endfunction

endpackage

// >>> hdl/cbr_reg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface cbr_reg_if;
  logic req;
  logic we;
  logic [2:0] addr;
  logic [31:0] wdata;
  logic ack;
  logic [31:0] rdata;
  modport dev (input req, we, addr, wdata, output ack, rdata);
  modport host (output req, we, addr, wdata, input ack, rdata);
endinterface
`default_nettype wire

// >>> hdl/cbr_watchdog.sv
`timescale 1ns/10ps
`default_nettype none
module cbr_watchdog #(
  parameter int CYCLES = cbr_pkg::WDT_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Control
  input wire logic enable,
  input wire logic kick,
  // Timeout pulse
  output logic expired
);
  import cbr_pkg::*;

  typedef struct packed {
    logic [WDT_CNT_W-1:0] cnt;
    logic fire;
  } cbr_wdt_t;

  cbr_wdt_t s;
  cbr_wdt_t next_s;

  always_comb begin
    next_s = s;
    next_s.fire = 1'b0;
    if (!enable || kick) begin
      next_s.cnt = '0;
    end else if (s.cnt == WDT_CNT_W'(CYCLES - 1)) begin
      next_s.cnt = '0;
      next_s.fire = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign expired = s.fire;
endmodule
`default_nettype wire

// >>> hdl/cbr_device.sv
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
module cbr_device #(
  parameter int WDT_CYCLES = cbr_pkg::WDT_CYCLES,
  parameter logic [7:0] WATCHDOG_LOCK = cbr_pkg::WATCHDOG_LOCK_DEF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port toward the host
  cbr_reg_if.dev bus,
  // Pins
  input wire logic [3:0] strap_pins,
  input wire logic debug_select_n,
  // Reset outputs
  output logic cpu_reset,
  output logic subsystem_reset,
  output logic chip_reset,
  output logic serdes_pll_reset,
  // Configuration outputs
  output logic cpu_run,
  output logic cpu_big_endian_enable,
  output logic boot_map_active,
  output logic serial_iface_owner,
  output logic serial_slave_enable,
  output logic mgmt_slave_enable,
  output logic cpu_debug_port_sel
);
  import cbr_pkg::*;

  typedef struct packed {
    cbr_dev_st_t st;
    logic [2:0] dly;
    logic [3:0] strap_s1;
    logic [3:0] strap_s2;
    logic [3:0] strap_lat;
    logic dbg_s1;
    logic dbg_s2;
    logic [4:0] gen;
    logic cpu_only;
    logic protect;
    logic wdt_en;
    logic wdt_cause;
    logic kick;
    logic lock_err;
    logic [31:0] scratch;
    logic [31:0] alt;
    logic [3:0] rst_cnt;
    logic rst_cpu;
    logic rst_sub;
    logic rst_chip;
    logic rst_serdes;
    logic map_boot;
    logic ack;
    logic [31:0] rdata;
    logic run;
    logic ser_slave;
    logic dbg_cpu;
  } cbr_dev_t;

  cbr_dev_t s;
  cbr_dev_t next_s;
  logic wdt_fire;

  cbr_watchdog #(
    .CYCLES(WDT_CYCLES)
  ) u_wdt (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .enable(s.wdt_en),
    .kick(s.kick),
    .expired(wdt_fire)
  );

  always_comb begin
    logic ev_force;
    logic ev_chip;
    logic ev_switch;
    logic from_wdt;
    ev_force = 1'b0;
    ev_chip = 1'b0;
    ev_switch = 1'b0;
    from_wdt = 1'b0;
    next_s = s;
    next_s.ack = 1'b0;
    next_s.kick = 1'b0;
    next_s.lock_err = 1'b0;
    next_s.strap_s1 = strap_pins;
    next_s.strap_s2 = s.strap_s1;
    next_s.dbg_s1 = debug_select_n;
    next_s.dbg_s2 = s.dbg_s1;
    next_s.dbg_cpu = ~s.dbg_s2;
    case (s.st)
      CBR_STRAP: begin
        // Straps settle a few cycles after release before being caught
        if (s.dly == STRAP_DELAY_CYC - 3'h1) begin
          next_s.strap_lat = s.strap_s2;
          next_s.gen = cbr_strap_decode(s.strap_s2);
          next_s.st = CBR_RUN;
        end else begin
          next_s.dly = s.dly + 3'h1;
        end
      end
      CBR_RUN: begin
        if (bus.req && !s.ack) begin
          next_s.ack = 1'b1;
          next_s.rdata = '0;
          if (bus.we) begin
            if (bus.addr == REG_GEN) begin
              next_s.gen = bus.wdata[4:0];
            end else if (bus.addr == REG_CORE) begin
              next_s.cpu_only = bus.wdata[CORE_CPU_ONLY];
              next_s.protect = bus.wdata[CORE_PROTECT];
              ev_force = bus.wdata[CORE_FORCE];
            end else if (bus.addr == REG_CHIP) begin
              ev_chip = bus.wdata[CHIP_ALL];
              ev_switch = bus.wdata[CHIP_SWITCH];
            end else if (bus.addr == REG_WDT) begin
              // A write with the right key both sets enable and restarts
              if (bus.wdata[WATCHDOG_LOCK_LO +: 8] == WATCHDOG_LOCK) begin
                next_s.wdt_en = bus.wdata[WDT_ENA];
                next_s.kick = 1'b1;
              end else begin
                next_s.lock_err = 1'b1;
              end
            end else if (bus.addr == REG_SCRATCH) begin
              next_s.scratch = bus.wdata;
            end else if (bus.addr == REG_ALT) begin
              next_s.alt = bus.wdata;
            end
          end else begin
            if (bus.addr == REG_GEN) begin
              next_s.rdata = {27'h0, s.gen};
              next_s.map_boot = s.gen[GEN_BOOT];
            end else if (bus.addr == REG_CORE) begin
              next_s.rdata = {29'h0, s.protect, s.cpu_only, 1'b0};
            end else if (bus.addr == REG_WDT) begin
              next_s.rdata = {30'h0, s.wdt_cause, s.wdt_en};
            end else if (bus.addr == REG_SCRATCH) begin
              next_s.rdata = s.scratch;
            end else if (bus.addr == REG_ALT) begin
              next_s.rdata = s.alt;
            end
          end
        end
        from_wdt = wdt_fire | s.lock_err;
        ev_force = ev_force | from_wdt;
        if (s.rst_cnt != 4'h0) begin
          // Triggers during a running pulse are absorbed by it
          next_s.rst_cnt = s.rst_cnt - 4'h1;
          if (s.rst_cnt == 4'h1) begin
            next_s.rst_cpu = 1'b0;
            next_s.rst_sub = 1'b0;
            next_s.rst_chip = 1'b0;
            next_s.rst_serdes = 1'b0;
          end
        end else if (ev_force) begin
          next_s.rst_cnt = RST_PULSE_CYC;
          next_s.rst_cpu = 1'b1;
          next_s.rst_sub = ~s.cpu_only;
          next_s.wdt_cause = from_wdt;
          next_s.wdt_en = 1'b0;
          if (!s.cpu_only) begin
            // Owner and management enable stay: those slaves sit outside
            next_s.gen[GEN_BOOT] = 1'b1;
            next_s.map_boot = 1'b1;
          end
        end else if (ev_chip || ev_switch) begin
          next_s.rst_cnt = RST_PULSE_CYC;
          next_s.rst_chip = 1'b1;
          next_s.rst_serdes = ev_chip;
          if (!s.protect) begin
            next_s.rst_cpu = 1'b1;
            next_s.rst_sub = 1'b1;
            next_s.wdt_cause = 1'b0;
            next_s.wdt_en = 1'b0;
            next_s.gen = cbr_strap_decode(s.strap_lat);
            next_s.map_boot = 1'b1;
            next_s.cpu_only = 1'b0;
            next_s.protect = 1'b0;
            // Scratch and pin function words are left as they are
            next_s.scratch = s.scratch;
          end
        end
      end
      default: begin
        next_s.st = CBR_STRAP;
      end
    endcase
    next_s.run = ~next_s.gen[GEN_CPU_DISABLE] & ~next_s.rst_cpu;
    next_s.ser_slave = ~next_s.gen[GEN_OWNER];
  end

  // Only an external reset clears the scratch and pin function words
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.st <= CBR_STRAP;
      s.gen <= 5'h06;
      s.map_boot <= 1'b1;
      s.dbg_s1 <= 1'b1;
      s.dbg_s2 <= 1'b1;
      s.ser_slave <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign bus.ack = s.ack;
  assign bus.rdata = s.rdata;
  assign cpu_reset = s.rst_cpu;
  assign subsystem_reset = s.rst_sub;
  assign chip_reset = s.rst_chip;
  assign serdes_pll_reset = s.rst_serdes;
  assign cpu_run = s.run;
  assign cpu_big_endian_enable = s.gen[GEN_BE];
  assign boot_map_active = s.map_boot;
  assign serial_iface_owner = s.gen[GEN_OWNER];
  assign serial_slave_enable = s.ser_slave;
  assign mgmt_slave_enable = s.gen[GEN_MGMT];
  assign cpu_debug_port_sel = s.dbg_cpu;
endmodule
`default_nettype wire

// >>> hdl/cbr_host.sv
`timescale 1ns/10ps
`default_nettype none
module cbr_host (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Classic Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:2] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // Register port toward the device
  cbr_reg_if.host bus,
  // Frame DMA enable
  output logic frame_dma_enable
);
  import cbr_pkg::*;

  typedef struct packed {
    cbr_host_st_t st;
    logic ack;
    logic [31:0] dat;
    logic req;
    logic we;
    logic [2:0] addr;
    logic [31:0] wdata;
    logic dma_en;
  } cbr_host_t;

  cbr_host_t s;
  cbr_host_t next_s;

  always_comb begin
    logic stops_dma;
    next_s = s;
    next_s.ack = 1'b0;
    stops_dma = 1'b0;
    case (s.st)
      CBR_IDLE: begin
        if (wb_cyc_i && wb_stb_i && !s.ack) begin
          if (wb_adr_i == REG_HOST) begin
            next_s.ack = 1'b1;
            next_s.dat = {31'h0, s.dma_en};
            if (wb_we_i && wb_sel_i[0]) begin
              next_s.dma_en = wb_dat_i[HOST_DMA_ENA];
            end
          end else if (wb_adr_i <= REG_ALT) begin
            next_s.req = 1'b1;
            next_s.we = wb_we_i;
            next_s.addr = wb_adr_i;
            next_s.wdata = wb_dat_i;
            next_s.st = CBR_FWD;
            if (wb_adr_i == REG_CORE) begin
              stops_dma = wb_dat_i[CORE_FORCE];
            end else if (wb_adr_i == REG_CHIP) begin
              stops_dma = wb_dat_i[CHIP_ALL] | wb_dat_i[CHIP_SWITCH];
            end
            // DMA drops on the edge that takes the reset write, a cycle before the reset pulse starts
            if (wb_we_i && stops_dma) begin
              next_s.dma_en = 1'b0;
            end
          end else begin
            next_s.ack = 1'b1;
            next_s.dat = '0;
          end
        end
      end
      CBR_FWD: begin
        if (bus.ack) begin
          next_s.req = 1'b0;
          if (s.we && s.addr == REG_GEN) begin
            // Read back so the device applies the new mapping
            next_s.req = 1'b1;
            next_s.we = 1'b0;
            next_s.st = CBR_READBACK;
          end else begin
            next_s.ack = 1'b1;
            next_s.dat = bus.rdata;
            next_s.st = CBR_IDLE;
          end
        end
      end
      CBR_READBACK: begin
        if (bus.ack) begin
          next_s.req = 1'b0;
          next_s.ack = 1'b1;
          next_s.dat = bus.rdata;
          next_s.st = CBR_IDLE;
        end
      end
      default: begin
        next_s.st = CBR_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.st <= CBR_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.dat;
  assign bus.req = s.req;
  assign bus.we = s.we;
  assign bus.addr = s.addr;
  assign bus.wdata = s.wdata;
  assign frame_dma_enable = s.dma_en;
endmodule
`default_nettype wire

// >>> bench/cbr_link_chk.sv
`timescale 1ns/10ps
`default_nettype none
module cbr_link_chk
  import cbr_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register port
  input wire logic req,
  input wire logic we,
  input wire logic [2:0] addr,
  input wire logic [31:0] wdata,
  input wire logic ack,
  input wire logic [31:0] rdata
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_ack_pulse;
    ack |=> !ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack wider than one cycle");
  property p_ack_req;
    ack |-> req;
  endproperty
  a_ack_req: assert property (p_ack_req)
    else $error("ack without request");
  property p_hold;
    req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata);
  endproperty
  a_hold: assert property (p_hold)
    else $error("request changed before ack");
  // Strap wait after reset can delay the first answer by a few cycles
  property p_answer;
    req && !ack |-> ##[1:8] ack;
  endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered");
  property p_wr_zero;
    ack && we |-> rdata == 32'h0;
  endproperty
  a_wr_zero: assert property (p_wr_zero)
    else $error("read data on write");
  // Reset triggers are write-only and must read back as zero
  property p_trig_read;
    ack && !we && addr == REG_CHIP |-> rdata == 32'h0;
  endproperty
  a_trig_read: assert property (p_trig_read)
    else $error("reset trigger register returned data");
  property p_key_hidden;
    ack && !we && addr == REG_WDT |-> rdata[31:8] == 24'h0;
  endproperty
  a_key_hidden: assert property (p_key_hidden)
    else $error("lock key readable");
  property p_readback;
    ack && we && addr == REG_GEN |-> ##[1:3] (req && !we && addr == REG_GEN);
  endproperty
  a_readback: assert property (p_readback)
    else $error("no read-back after mapping write");

  c_gen_wr: cover property (ack && we && addr == REG_GEN);
  c_wdt_wr: cover property (ack && we && addr == REG_WDT);
  c_chip_wr: cover property (ack && we && addr == REG_CHIP);
endmodule
`default_nettype wire

// >>> bench/cbr_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module cbr_tb_top;
  import cbr_pkg::*;
  localparam int WCYC = 50;
  localparam logic [7:0] P = 8'(RST_PULSE_CYC);
  localparam logic [31:0] K = {16'h0, WATCHDOG_LOCK_DEF, 8'h01};
  logic sys_clk, reset_n, cyc, stb, wwe, ack_o, dma, dbg_n;
  logic [4:2] adr;
  logic [3:0] sel, strap;
  logic [31:0] wd, rd_o, q;
  logic cpu_r, sub_r, chip_r, ser_r, run, be, map, own, sle, mgmt, dsel;
  logic [3:0] sv [5] = '{4'h0, 4'hC, 4'hA, 4'hB, 4'h9};
  logic [4:0] gv [5] = '{5'h03, 5'h0B, 5'h16, 5'h16, 5'h06};
  int err_count, compares, n_cpu, n_sub, n_chip, n_ser;

  cbr_reg_if link();
  cbr_host cbr_host_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(wwe), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wd), .wb_ack_o(ack_o), .wb_dat_o(rd_o),
    .bus(link), .frame_dma_enable(dma));
  cbr_device #(.WDT_CYCLES(WCYC)) cbr_device_i (.sys_clk(sys_clk),
    .reset_n(reset_n), .bus(link), .strap_pins(strap),
    .debug_select_n(dbg_n), .cpu_reset(cpu_r), .subsystem_reset(sub_r),
    .chip_reset(chip_r), .serdes_pll_reset(ser_r), .cpu_run(run),
    .cpu_big_endian_enable(be), .boot_map_active(map),
    .serial_iface_owner(own), .serial_slave_enable(sle),
    .mgmt_slave_enable(mgmt), .cpu_debug_port_sel(dsel));
  cbr_link_chk cbr_link_chk_i (.sys_clk(sys_clk), .reset_n(reset_n),
    .req(link.req), .we(link.we), .addr(link.addr), .wdata(link.wdata),
    .ack(link.ack), .rdata(link.rdata));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task summarize;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task chk32(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task chk1(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("Error %0t: flag %b want %b", $time, got, exp);
    end
  endtask

  // One classic Wishbone cycle; the answer delay is never assumed and
  // only the watchdog process below ends a hung wait
  task tx(input logic w, input logic [2:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    wwe <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge sys_clk);
    end while (ack_o !== 1'b1);
    q = rd_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task rd(input logic [2:0] a, input logic [31:0] exp);
    tx(1'b0, a, 32'h0);
    chk32(q, exp);
  endtask

  // Counts the high cycles of each reset output over a window
  task rst_chk(input int c, input logic [31:0] exp);
    n_cpu = 0;
    n_sub = 0;
    n_chip = 0;
    n_ser = 0;
    repeat (c) begin
      @(posedge sys_clk);
      n_cpu += int'(cpu_r);
      n_sub += int'(sub_r);
      n_chip += int'(chip_r);
      n_ser += int'(ser_r);
    end
    chk32({n_cpu[7:0], n_sub[7:0], n_chip[7:0], n_ser[7:0]}, exp);
  endtask

  // Counting starts with the write, since a pulse begins before the
  // Wishbone answer and would otherwise be cut short
  task rst_wr(input logic [2:0] a, input logic [31:0] d,
    input logic [31:0] exp);
    fork
      tx(1'b1, a, d);
      rst_chk(20, exp);
    join
  endtask

  task do_reset(input logic [3:0] s);
    strap <= s;
    reset_n <= 1'b0;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge sys_clk);
  endtask

  initial begin
    reset_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    wwe = 1'b0;
    adr = 3'h0;
    sel = 4'hF;
    wd = 32'h0;
    strap = 4'h9;
    dbg_n = 1'b1;
    err_count = 0;
    compares = 0;
    for (int i = 0; i < 5; i++) begin
      do_reset(sv[i]);
      rd(REG_GEN, {27'h0, gv[i]});
      chk1(own, gv[i][GEN_OWNER]);
      chk1(run, !gv[i][GEN_CPU_DISABLE]);
      chk1(sle, !gv[i][GEN_OWNER]);
      chk1(mgmt, gv[i][GEN_MGMT]);
      chk1(be, gv[i][GEN_BE]);
      chk1(map, 1'b1);
    end
    dbg_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    chk1(dsel, 1'b1);
    dbg_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk1(dsel, 1'b0);
    tx(1'b1, REG_GEN, 32'h3);
    repeat (2) @(posedge sys_clk);
    chk1(own, 1'b1);
    chk1(sle, 1'b0);
    chk1(run, 1'b1);
    tx(1'b1, REG_GEN, 32'h8);
    repeat (2) @(posedge sys_clk);
    chk1(map, 1'b0);
    chk1(be, 1'b1);
    chk1(sle, 1'b1);
    tx(1'b1, REG_GEN, 32'h18);
    repeat (2) @(posedge sys_clk);
    chk1(mgmt, 1'b1);
    tx(1'b1, REG_SCRATCH, 32'hA5A5_5A5A);
    tx(1'b1, REG_ALT, 32'h0000_00C3);
    tx(1'b1, REG_HOST, 32'h0000_0001);
    chk1(dma, 1'b1);
    rd(REG_HOST, 32'h0000_0001);
    tx(1'b1, 3'h6, 32'hFFFF_FFFF);
    rd(3'h6, 32'h0);
    tx(1'b1, REG_CORE, 32'h2);
    chk1(dma, 1'b1);
    rst_wr(REG_CORE, 32'h3, {P, 24'h0});
    chk1(dma, 1'b0);
    chk1(map, 1'b0);
    // A force obeys the cpu-only setting that stood before its write
    tx(1'b1, REG_CORE, 32'h0);
    rst_wr(REG_CORE, 32'h1, {P, P, 16'h0});
    chk1(map, 1'b1);
    tx(1'b1, REG_CORE, 32'h4);
    rd(REG_CORE, 32'h4);
    chk1(dma, 1'b0);
    rst_wr(REG_CHIP, 32'h1, {16'h0, P, P});
    rd(REG_CHIP, 32'h0);
    tx(1'b1, REG_CORE, 32'h0);
    rst_wr(REG_CHIP, 32'h2, {P, P, P, 8'h0});
    rd(REG_GEN, 32'h6);
    rd(REG_SCRATCH, 32'hA5A5_5A5A);
    rd(REG_ALT, 32'h0000_00C3);
    rd(REG_WDT, 32'h0);
    // Kicks are spaced well inside the shortened timeout
    repeat (4) begin
      tx(1'b1, REG_WDT, K);
      rst_chk(30, 32'h0);
    end
    rst_chk(70, {P, P, 16'h0});
    rd(REG_WDT, 32'h2);
    rst_wr(REG_WDT, 32'h0000_0001, {P, P, 16'h0});
    rst_wr(REG_CORE, 32'h1, {P, P, 16'h0});
    rd(REG_WDT, 32'h0);
    summarize;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    $display("Error %0t: timeout", $time);
    summarize;
  end
endmodule
`default_nettype wire
